//--- ivfm_pkg.sv
// Command codes, field layout, reset values, states and helpers of the
// input-voltage fault monitor. Assumes a command front end outside the block.
package ivfm_pkg;
   // Command codes
   localparam logic [7:0] CMD_OV_WARN = 8'h57;
   localparam logic [7:0] CMD_UV_WARN = 8'h58;
   localparam logic [7:0] CMD_UV_FAULT = 8'h59;
   localparam logic [7:0] CMD_UV_ACTION = 8'h5a;
   // Fault action byte layout
   localparam int ACT_RESP_HI = 7;
   localparam int ACT_RESP_LO = 6;
   localparam int ACT_RETRY_HI = 5;
   localparam int ACT_RETRY_LO = 3;
   localparam int ACT_DLY_HI = 2;
   localparam int ACT_DLY_LO = 0;
   // Response codes
   localparam logic [1:0] RESP_IGNORE = 2'h0;
   localparam logic [1:0] RESP_DELAY = 2'h1;
   localparam logic [1:0] RESP_RETRY = 2'h2;
   localparam logic [1:0] RESP_LATCH = 2'h3;
   // Retry codes
   localparam logic [2:0] RETRY_NONE = 3'h0;
   localparam logic [2:0] RETRY_FOREVER = 3'h7;
   // Reset values: thresholds in linear format, exponent -2
   localparam logic [15:0] RST_OV_WARN = 16'hf0e8;
   localparam logic [15:0] RST_UV_WARN = 16'hf0a8;
   localparam logic [15:0] RST_UV_FAULT = 16'hf098;
   localparam logic [7:0] RST_UV_ACTION = 8'h80;
   // Linear format layout
   localparam int LIN_EXP_HI = 15;
   localparam int LIN_EXP_LO = 11;
   localparam int LIN_MAN_HI = 10;
   // Fraction bits of the measured input voltage
   localparam int MEAS_FRAC = 8;

   typedef enum logic [3:0]
   {
      ST_RUN = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_RETRY = 4'b0100,
      ST_LATCH = 4'b1000
   } ivfm_state_t;

   // Delay units for a delay code; code 1 has no defined count, taken as 2
   function automatic logic [7:0] ivfm_delay_units(input logic [2:0] code);
      logic [7:0] units;
      units = 8'h01;
      unique case (code)
         3'h0: units = 8'h01;
         3'h1: units = 8'h02;
         3'h2: units = 8'h04;
         3'h3: units = 8'h08;
         3'h4: units = 8'h10;
         3'h5: units = 8'h20;
         3'h6: units = 8'h40;
         3'h7: units = 8'h80;
      endcase
      return units;
   endfunction : ivfm_delay_units
endpackage : ivfm_pkg

//--- ivfm_lin_cmp.sv
// Linear-format threshold decoder and comparator.
// Assumes the measurement is unsigned volts with MEAS_FRAC fraction bits.
module ivfm_lin_cmp
   import ivfm_pkg::*;
#(
   parameter int MEAS_W = 16
)
(
   input wire logic [15:0] i_limit,
   input wire logic [MEAS_W-1:0] i_meas,
   output logic o_below,
   output logic o_above
);
   logic signed [4:0] lin_exp;
   logic signed [10:0] lin_man;
   logic signed [6:0] shift;
   logic signed [47:0] thr;
   logic signed [47:0] meas_s;

   always_comb
   begin
      lin_exp = i_limit[LIN_EXP_HI:LIN_EXP_LO];
      lin_man = i_limit[LIN_MAN_HI:0];
      shift = 7'(lin_exp) + 7'(MEAS_FRAC);
      thr = 48'(lin_man);
      // Negative shift drops fraction bits the measurement cannot resolve
      if (shift >= 0)
      begin
         thr = thr <<< shift;
      end
      else
      begin
         thr = thr >>> 7'(-shift);
      end
      meas_s = $signed({{(48 - MEAS_W){1'b0}}, i_meas});
      o_below = meas_s < thr;
      o_above = meas_s > thr;
   end
endmodule : ivfm_lin_cmp

//--- ivfm_top.sv
// Input-voltage supervision: warning and fault thresholds, the fault action
// byte, and the fault response sequencer. Assumes a command front end on the
// same clock, a delay-unit tick from the time-unit logic, and an ADC sample.
//
// Behaviour
// - Hold 16-bit input over-voltage warning threshold at code 0x57, read/write.
// - Value at 0x58 is both under-voltage warning and ratio-regulation threshold.
// - Ratio regulation acts only when enabled by the vendor option settings.
// - Hold 16-bit input under-voltage fault threshold at code 0x59.
// - Response 00: keep operating through an under-voltage fault.
// - Response 01: keep operating for delay count times delay unit.
// - Response 01: fault still present at delay end, follow retry setting.
// - Response 10: disable output at once, then follow retry setting.
// - Response 11: latch off until status clear, clear-faults or reset.
// - Commanding output off then on also clears a latched fault.
// - Retry 000: no restart, output stays off until fault cleared.
// - Retry 001: exactly one restart attempt.
// - Retry 010 gives two attempts, 011 gives three.
// - Attempt starts spaced by delay count times delay unit.
// - All attempts failed: output off and latched until cleared.
// - Retry 100, 101, 110 give four, five, six attempts, then latch.
// - Retry 111 retries without limit until commanded off.
// - Delay code maps to 1, 4, 8, 16, 32, 64, 128 units.
module ivfm_top
   import ivfm_pkg::*;
#(
   parameter int MEAS_W = 16
)
(
   input wire logic I_REF_CLK,
   input wire logic I_SRST,
   input wire logic i_CMD_VALID,
   input wire logic i_CMD_WRITE,
   input wire logic [7:0] i_CMD_CODE,
   input wire logic [15:0] i_CMD_WDATA,
   output logic [15:0] o_CMD_RDATA,
   output logic o_CMD_ACK,
   output logic o_CMD_NACK,
   input wire logic [MEAS_W-1:0] i_VIN_MEAS,
   input wire logic i_UNIT_TICK,
   input wire logic i_CTRL_PIN,
   input wire logic i_OPERATION_ON,
   input wire logic i_CLEAR_FAULTS,
   input wire logic i_CLEAR_UV_FAULT,
   input wire logic i_RATIO_REG_EN,
   output logic o_OUTPUT_EN,
   output logic o_UV_FAULT,
   output logic o_UV_WARN,
   output logic o_OV_WARN,
   output logic o_RETRYING,
   output logic o_LATCHED_OFF,
   output logic o_RATIO_REG_BELOW
);
   logic [15:0] ov_warn_q;
   logic [15:0] uv_warn_q;
   logic [15:0] uv_fault_lim_q;
   logic [7:0] uv_action_q;
   logic ctrl_meta_q;
   logic ctrl_sync_q;
   logic cmd_on_prev_q;
   logic cmd_on;
   logic on_rise;
   logic clear_latch;
   logic ov_above;
   logic uv_warn_below;
   logic uv_fault_below;
   logic [1:0] resp;
   logic [2:0] retry;
   logic [7:0] units;
   logic [7:0] tick_cnt_q;
   logic [2:0] tries_q;
   logic interval_done;
   logic attempts_used;
   ivfm_state_t state_q;
   ivfm_state_t state_d;
   ivfm_state_t after_fault;
   logic cmd_hit;

   // Pin is asynchronous to the clock
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         ctrl_meta_q <= 1'b0;
         ctrl_sync_q <= 1'b0;
      end
      else
      begin
         ctrl_meta_q <= i_CTRL_PIN;
         ctrl_sync_q <= ctrl_meta_q;
      end
   end

   assign cmd_on = ctrl_sync_q & i_OPERATION_ON;
   assign on_rise = cmd_on & ~cmd_on_prev_q;

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         cmd_on_prev_q <= 1'b0;
      end
      else
      begin
         cmd_on_prev_q <= cmd_on;
      end
   end

   // Command registers
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         ov_warn_q <= RST_OV_WARN;
         uv_warn_q <= RST_UV_WARN;
         uv_fault_lim_q <= RST_UV_FAULT;
         uv_action_q <= RST_UV_ACTION;
      end
      else if (i_CMD_VALID && i_CMD_WRITE)
      begin
         unique case (i_CMD_CODE)
            CMD_OV_WARN: ov_warn_q <= i_CMD_WDATA;
            CMD_UV_WARN: uv_warn_q <= i_CMD_WDATA;
            CMD_UV_FAULT: uv_fault_lim_q <= i_CMD_WDATA;
            CMD_UV_ACTION: uv_action_q <= i_CMD_WDATA[7:0];
            default: ;
         endcase
      end
   end

   always_comb
   begin
      cmd_hit = (i_CMD_CODE == CMD_OV_WARN) || (i_CMD_CODE == CMD_UV_WARN) ||
         (i_CMD_CODE == CMD_UV_FAULT) || (i_CMD_CODE == CMD_UV_ACTION);
   end

   // Answer one cycle after the request; unknown codes get a refusal
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         o_CMD_RDATA <= 16'h0000;
         o_CMD_ACK <= 1'b0;
         o_CMD_NACK <= 1'b0;
      end
      else
      begin
         o_CMD_ACK <= i_CMD_VALID & cmd_hit;
         o_CMD_NACK <= i_CMD_VALID & ~cmd_hit;
         if (i_CMD_VALID && !i_CMD_WRITE)
         begin
            unique case (i_CMD_CODE)
               CMD_OV_WARN: o_CMD_RDATA <= ov_warn_q;
               CMD_UV_WARN: o_CMD_RDATA <= uv_warn_q;
               CMD_UV_FAULT: o_CMD_RDATA <= uv_fault_lim_q;
               CMD_UV_ACTION: o_CMD_RDATA <= {8'h00, uv_action_q};
               default: o_CMD_RDATA <= 16'h0000;
            endcase
         end
      end
   end

   ivfm_lin_cmp #(.MEAS_W(MEAS_W)) u_cmp_ov
   (
      .i_limit(ov_warn_q),
      .i_meas(i_VIN_MEAS),
      .o_below(),
      .o_above(ov_above)
   );

   ivfm_lin_cmp #(.MEAS_W(MEAS_W)) u_cmp_uv_warn
   (
      .i_limit(uv_warn_q),
      .i_meas(i_VIN_MEAS),
      .o_below(uv_warn_below),
      .o_above()
   );

   ivfm_lin_cmp #(.MEAS_W(MEAS_W)) u_cmp_uv_fault
   (
      .i_limit(uv_fault_lim_q),
      .i_meas(i_VIN_MEAS),
      .o_below(uv_fault_below),
      .o_above()
   );

   assign resp = uv_action_q[ACT_RESP_HI:ACT_RESP_LO];
   assign retry = uv_action_q[ACT_RETRY_HI:ACT_RETRY_LO];
   assign units = ivfm_delay_units(uv_action_q[ACT_DLY_HI:ACT_DLY_LO]);
   assign interval_done = i_UNIT_TICK && (tick_cnt_q == units - 8'h01);
   // Attempt now ending is the last one allowed
   assign attempts_used = (retry != RETRY_FOREVER) &&
      ({1'b0, tries_q} + 4'h1 >= {1'b0, retry});
   // Off-then-on clears through the commanded-off path below
   assign clear_latch = i_CLEAR_FAULTS | i_CLEAR_UV_FAULT;

   always_comb
   begin
      after_fault = (retry == RETRY_NONE) ? ST_LATCH : ST_RETRY;
   end

   always_comb
   begin
      state_d = state_q;
      if (!cmd_on)
      begin
         state_d = ST_RUN;
      end
      else
      begin
         unique case (state_q)
            ST_RUN:
            begin
               if (uv_fault_below)
               begin
                  unique case (resp)
                     RESP_IGNORE: state_d = ST_RUN;
                     RESP_DELAY: state_d = ST_DELAY;
                     RESP_RETRY: state_d = after_fault;
                     RESP_LATCH: state_d = ST_LATCH;
                  endcase
               end
            end
            ST_DELAY:
            begin
               if (interval_done)
               begin
                  state_d = uv_fault_below ? after_fault : ST_RUN;
               end
            end
            ST_RETRY:
            begin
               if (interval_done)
               begin
                  if (!uv_fault_below)
                  begin
                     state_d = ST_RUN;
                  end
                  else if (attempts_used)
                  begin
                     state_d = ST_LATCH;
                  end
               end
            end
            ST_LATCH:
            begin
               if (clear_latch)
               begin
                  state_d = ST_RUN;
               end
            end
            default: state_d = ST_RUN;
         endcase
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         state_q <= ST_RUN;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Delay-unit counter restarts on every state change and interval end
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST || (state_d != state_q) || interval_done)
      begin
         tick_cnt_q <= 8'h00;
      end
      else if (i_UNIT_TICK && (state_q == ST_DELAY || state_q == ST_RETRY))
      begin
         tick_cnt_q <= tick_cnt_q + 8'h01;
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST || (state_q != ST_RETRY))
      begin
         tries_q <= 3'h0;
      end
      else if (interval_done && tries_q != 3'h7)
      begin
         tries_q <= tries_q + 3'h1;
      end
   end

   // Output permission follows the next state so a trip disables at once
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         o_OUTPUT_EN <= 1'b0;
         o_RETRYING <= 1'b0;
         o_LATCHED_OFF <= 1'b0;
      end
      else
      begin
         o_OUTPUT_EN <= cmd_on && (state_d == ST_RUN || state_d == ST_DELAY);
         o_RETRYING <= state_d == ST_RETRY;
         o_LATCHED_OFF <= state_d == ST_LATCH;
      end
   end

   // Sticky status; a set in the clearing cycle wins
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         o_UV_FAULT <= 1'b0;
         o_UV_WARN <= 1'b0;
         o_OV_WARN <= 1'b0;
      end
      else
      begin
         o_UV_FAULT <= uv_fault_below | (o_UV_FAULT & ~clear_latch);
         o_UV_WARN <= uv_warn_below | (o_UV_WARN & ~i_CLEAR_FAULTS);
         o_OV_WARN <= ov_above | (o_OV_WARN & ~i_CLEAR_FAULTS);
      end
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
      begin
         o_RATIO_REG_BELOW <= 1'b0;
      end
      else
      begin
         o_RATIO_REG_BELOW <= i_RATIO_REG_EN & uv_warn_below;
      end
   end
endmodule : ivfm_top

//--- ivfm_top_properties.sv
// Checker on ivfm_top ports: command answers and fault actions.
// Assumes one clock domain; bound to every ivfm_top.
module ivfm_top_properties
   import ivfm_pkg::*;
(
   input wire logic I_REF_CLK,
   input wire logic I_SRST,
   input wire logic i_CMD_VALID,
   input wire logic i_CMD_WRITE,
   input wire logic [7:0] i_CMD_CODE,
   input wire logic [15:0] i_CMD_WDATA,
   input wire logic o_CMD_ACK,
   input wire logic o_CMD_NACK,
   input wire logic i_UNIT_TICK,
   input wire logic i_CTRL_PIN,
   input wire logic i_OPERATION_ON,
   input wire logic i_CLEAR_FAULTS,
   input wire logic i_CLEAR_UV_FAULT,
   input wire logic i_RATIO_REG_EN,
   input wire logic o_OUTPUT_EN,
   input wire logic o_RETRYING,
   input wire logic o_LATCHED_OFF,
   input wire logic o_RATIO_REG_BELOW
);
   default clocking @(posedge I_REF_CLK);
   endclocking
   default disable iff (I_SRST);
   // Shadow of the action byte, so checks know the mode
   logic [7:0] act_q;
   logic known;
   assign known = i_CMD_CODE >= CMD_OV_WARN && i_CMD_CODE <= CMD_UV_ACTION;
   always_ff @(posedge I_REF_CLK)
   begin
      if (I_SRST)
         act_q <= RST_UV_ACTION;
      else if (i_CMD_VALID && i_CMD_WRITE && i_CMD_CODE == CMD_UV_ACTION)
         act_q <= i_CMD_WDATA[7:0];
   end
   a_ack_known: assert property (i_CMD_VALID && known |=> o_CMD_ACK && !o_CMD_NACK)
      else $error("no ack");
   a_nack_unknown: assert property (i_CMD_VALID && !known |=> o_CMD_NACK && !o_CMD_ACK)
      else $error("no nack");
   a_ignore_runs: assert property (act_q[7:6] == RESP_IGNORE && !o_RETRYING && !o_LATCHED_OFF
      |=> !o_RETRYING && !o_LATCHED_OFF)
      else $error("ignore mode stopped");
   a_retry_off: assert property (o_RETRYING |-> !o_OUTPUT_EN)
      else $error("on while retrying");
   a_latch_off: assert property (o_LATCHED_OFF |-> !o_OUTPUT_EN && !o_RETRYING)
      else $error("latch not off");
   a_clear_exits: assert property (o_LATCHED_OFF && i_CLEAR_FAULTS |=> !o_LATCHED_OFF)
      else $error("latch kept");
   a_forever_no_latch: assert property (act_q[5:3] == RETRY_FOREVER && o_RETRYING
      |=> !o_LATCHED_OFF)
      else $error("endless retry latched");
   a_retry_waits: assert property (o_RETRYING && !i_UNIT_TICK && i_OPERATION_ON && i_CTRL_PIN
      && $past(i_CTRL_PIN, 2) |=> o_RETRYING)
      else $error("retry left without tick");
   a_ratio_gate: assert property (!i_RATIO_REG_EN |=> !o_RATIO_REG_BELOW)
      else $error("ratio flag while disabled");
   // Synchronised pin two edges back decides the commanded-on state now
   a_latch_holds: assert property (o_LATCHED_OFF && !i_CLEAR_FAULTS
      && !i_CLEAR_UV_FAULT && i_OPERATION_ON && $past(i_CTRL_PIN, 2) |=> o_LATCHED_OFF)
      else $error("latch lost without clear");
endmodule : ivfm_top_properties

bind ivfm_top ivfm_top_properties i_ivfm_top_properties (.I_REF_CLK, .I_SRST, .i_CMD_VALID,
   .i_CMD_WRITE, .i_CMD_CODE, .i_CMD_WDATA, .o_CMD_ACK, .o_CMD_NACK, .i_UNIT_TICK, .i_CTRL_PIN,
   .i_OPERATION_ON, .i_CLEAR_FAULTS, .i_CLEAR_UV_FAULT, .i_RATIO_REG_EN, .o_OUTPUT_EN,
   .o_RETRYING, .o_LATCHED_OFF, .o_RATIO_REG_BELOW);

//--- ivfm_host.sv
// Host controller model: commands, on/off and fault clears.
// Assumes the device answers one cycle after each request.
module ivfm_host
(
   input wire logic i_clk,
   input wire logic [15:0] i_rdata,
   input wire logic i_ack,
   input wire logic i_nack,
   output logic o_valid,
   output logic o_write,
   output logic [7:0] o_code,
   output logic [15:0] o_wdata,
   output logic o_op_on,
   output logic o_clr_all,
   output logic o_clr_uv
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      {o_valid, o_write, o_code, o_wdata, o_clr_all, o_clr_uv} = '0;
      o_op_on = 1'b1;
   end
   task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
      output logic [15:0] r, output logic a, output logic n);
      @(negedge i_clk);
      {o_valid, o_write, o_code, o_wdata} = {1'b1, w, c, d};
      @(negedge i_clk);
      o_valid = 1'b0;
      // Stale data must not pass for a fresh request
      o_wdata = ~o_wdata;
      {r, a, n} = {i_rdata, i_ack, i_nack};
   endtask : cmd
   task automatic clear(input logic uv);
      @(negedge i_clk);
      {o_clr_uv, o_clr_all} = {uv, !uv};
      @(negedge i_clk);
      {o_clr_uv, o_clr_all} = 2'h0;
   endtask : clear
   task automatic power(input logic on);
      @(negedge i_clk);
      o_op_on = on;
   endtask : power
endmodule : ivfm_host

//--- ivfm_top_tb.sv
// Bench for ivfm_top: registers, warnings and fault actions.
// Assumes the host model drives commands, on/off and clears.
module ivfm_top_tb
   import ivfm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
   $display("MISMATCH %s exp %h got %h", nm, e, s); end end
   localparam logic [15:0] VIN_OK = 16'h3000;
   localparam logic [15:0] VIN_LOW = 16'h1e00;
   logic I_REF_CLK = 1'b0;
   logic I_SRST = 1'b1;
   logic i_CMD_VALID, i_CMD_WRITE, o_CMD_ACK, o_CMD_NACK, i_OPERATION_ON, i_CLEAR_FAULTS;
   logic i_UNIT_TICK, i_CTRL_PIN, i_CLEAR_UV_FAULT, i_RATIO_REG_EN, o_OUTPUT_EN, o_UV_FAULT;
   logic o_UV_WARN, o_OV_WARN, o_RETRYING, o_LATCHED_OFF, o_RATIO_REG_BELOW, ack, nack, en0;
   logic [7:0] i_CMD_CODE;
   logic [15:0] i_CMD_WDATA, o_CMD_RDATA, i_VIN_MEAS, rd;
   int n_fail = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   always #10 I_REF_CLK = ~I_REF_CLK;
   ivfm_top i_ivfm_top (.I_REF_CLK, .I_SRST, .i_CMD_VALID, .i_CMD_WRITE, .i_CMD_CODE,
      .i_CMD_WDATA, .o_CMD_RDATA, .o_CMD_ACK, .o_CMD_NACK, .i_VIN_MEAS, .i_UNIT_TICK,
      .i_CTRL_PIN, .i_OPERATION_ON, .i_CLEAR_FAULTS, .i_CLEAR_UV_FAULT, .i_RATIO_REG_EN,
      .o_OUTPUT_EN, .o_UV_FAULT, .o_UV_WARN, .o_OV_WARN, .o_RETRYING, .o_LATCHED_OFF,
      .o_RATIO_REG_BELOW);
   ivfm_host i_ivfm_host (.i_clk(I_REF_CLK), .i_rdata(o_CMD_RDATA), .i_ack(o_CMD_ACK),
      .i_nack(o_CMD_NACK), .o_valid(i_CMD_VALID), .o_write(i_CMD_WRITE), .o_code(i_CMD_CODE),
      .o_wdata(i_CMD_WDATA), .o_op_on(i_OPERATION_ON), .o_clr_all(i_CLEAR_FAULTS),
      .o_clr_uv(i_CLEAR_UV_FAULT));
   task automatic final_report;
      $display("%0d compares, %0d mismatches", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   always @(posedge I_REF_CLK)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         final_report();
      end
   end
   task automatic wait_n(input int k);
      repeat (k) @(negedge I_REF_CLK);
   endtask : wait_n
   task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
      i_ivfm_host.cmd(1'b0, c, 16'h0000, rd, ack, nack);
      `CHK("rdata", e, rd)
      `CHK("ack", 1'b1, ack)
   endtask : rd_chk
   task automatic wr(input logic [7:0] c, input logic [15:0] d);
      i_ivfm_host.cmd(1'b1, c, d, rd, ack, nack);
      `CHK("wack", 1'b1, ack)
   endtask : wr
   task automatic tick;
      i_UNIT_TICK = 1'b1;
      wait_n(1);
      i_UNIT_TICK = 1'b0;
      wait_n(2);
   endtask : tick
   // Ticks needed until latch-off, capped at lim
   task automatic fault(input logic [7:0] act, input int lim);
      wr(CMD_UV_ACTION, {8'h00, act});
      i_VIN_MEAS = VIN_LOW;
      wait_n(4);
      en0 = o_OUTPUT_EN;
      n = 0;
      while (o_LATCHED_OFF !== 1'b1 && n < lim)
      begin
         tick();
         n++;
      end
   endtask : fault
   task automatic recover(input logic uv);
      i_VIN_MEAS = VIN_OK;
      i_ivfm_host.clear(uv);
      wait_n(4);
      `CHK("en", 1'b1, o_OUTPUT_EN)
      `CHK("latch", 1'b0, o_LATCHED_OFF)
   endtask : recover
   initial
   begin
      {i_UNIT_TICK, i_RATIO_REG_EN, i_CTRL_PIN, i_VIN_MEAS} = {3'h1, VIN_OK};
      wait_n(3);
      I_SRST = 1'b0;
      wait_n(4);
      rd_chk(CMD_OV_WARN, RST_OV_WARN);
      rd_chk(CMD_UV_WARN, RST_UV_WARN);
      rd_chk(CMD_UV_FAULT, RST_UV_FAULT);
      rd_chk(CMD_UV_ACTION, {8'h00, RST_UV_ACTION});
      i_ivfm_host.cmd(1'b0, 8'h5b, 16'h0000, rd, ack, nack);
      `CHK("nack", 1'b1, nack)
      `CHK("nrd", 16'h0000, rd)
      wr(CMD_UV_WARN, 16'hf0b0);
      rd_chk(CMD_UV_WARN, 16'hf0b0);
      // New limits keep the later voltages on the same side: 56 V and 39 V
      wr(CMD_OV_WARN, 16'hf0e0);
      rd_chk(CMD_OV_WARN, 16'hf0e0);
      wr(CMD_UV_FAULT, 16'hf09c);
      rd_chk(CMD_UV_FAULT, 16'hf09c);
      wr(CMD_UV_ACTION, 16'hff80);
      rd_chk(CMD_UV_ACTION, 16'h0080);
      $display("test registers done");
      {i_VIN_MEAS, i_RATIO_REG_EN} = {16'h2a00, 1'b1};
      wait_n(3);
      `CHK("uvw", 1'b1, o_UV_WARN)
      `CHK("below", 1'b1, o_RATIO_REG_BELOW)
      `CHK("en", 1'b1, o_OUTPUT_EN)
      i_RATIO_REG_EN = 1'b0;
      wait_n(2);
      `CHK("below", 1'b0, o_RATIO_REG_BELOW)
      i_VIN_MEAS = 16'h3b00;
      wait_n(3);
      `CHK("ovw", 1'b1, o_OV_WARN)
      recover(1'b0);
      `CHK("uvw", 1'b0, o_UV_WARN)
      `CHK("ovw", 1'b0, o_OV_WARN)
      $display("test warnings done");
      fault(8'h00, 3);
      `CHK("en", 1'b1, o_OUTPUT_EN)
      `CHK("uvf", 1'b1, o_UV_FAULT)
      recover(1'b1);
      // Retry counts 0..6 at one unit per interval
      for (int r = 0; r < 7; r++)
      begin
         fault({2'h2, r[2:0], 3'h0}, 40);
         `CHK("ticks", r, n)
         `CHK("en0", 1'b0, en0)
         recover(r[0]);
      end
      fault({2'h2, 3'h3, 3'h2}, 60);
      `CHK("ticks", 12, n)
      i_VIN_MEAS = VIN_OK;
      i_ivfm_host.power(1'b0);
      wait_n(3);
      i_ivfm_host.power(1'b1);
      wait_n(3);
      `CHK("en", 1'b1, o_OUTPUT_EN)
      $display("test retries done");
      fault({2'h1, 3'h0, 3'h3}, 40);
      `CHK("en0", 1'b1, en0)
      `CHK("ticks", 8, n)
      recover(1'b1);
      fault({2'h1, 3'h0, 3'h7}, 200);
      `CHK("ticks", 128, n)
      recover(1'b1);
      fault({2'h1, 3'h0, 3'h1}, 10);
      `CHK("ticks", 2, n)
      recover(1'b1);
      fault({2'h2, 3'h1, 3'h0}, 0);
      `CHK("retry", 1'b1, o_RETRYING)
      i_VIN_MEAS = VIN_OK;
      tick();
      `CHK("en", 1'b1, o_OUTPUT_EN)
      recover(1'b1);
      fault({2'h2, 3'h7, 3'h0}, 20);
      `CHK("ticks", 20, n)
      `CHK("retry", 1'b1, o_RETRYING)
      i_ivfm_host.power(1'b0);
      wait_n(2);
      `CHK("retry", 1'b0, o_RETRYING)
      i_VIN_MEAS = VIN_OK;
      i_ivfm_host.power(1'b1);
      wait_n(3);
      `CHK("en", 1'b1, o_OUTPUT_EN)
      $display("test actions done");
      final_report();
   end
endmodule : ivfm_top_tb
